// >>> hw/ssipr_pkg.sv
/*
 * Constants for the absolute position readout over a synchronous serial link.
 * Assumes a 50 MHz system clock; the CYC counts below are in cycles of that clock.
 */
package ssipr_pkg;

   // System clock rate in kHz.
   localparam int unsigned CLK_KHZ            = 50000;
   // Word lengths for single-turn and multi-turn encoders.
   localparam int unsigned ST_BITS            = 13;
   localparam int unsigned MT_BITS            = 12;
   localparam int unsigned WORD_ST            = 13;
   localparam int unsigned WORD_MT            = 25;
   // Speed sample period, shortest and longest allowed, in microseconds.
   localparam int unsigned SAMPLE_MIN_US      = 125;
   localparam int unsigned SAMPLE_MAX_US      = 250;
   localparam int unsigned SAMPLE_MIN_CYC     = (SAMPLE_MIN_US * CLK_KHZ + 999) / 1000;
   localparam int unsigned SAMPLE_MAX_CYC     = (SAMPLE_MAX_US * CLK_KHZ) / 1000;
   // Half period of the generated shift clock, in nanoseconds.
   localparam int unsigned HALF_CLK_NS        = 1000;
   localparam int unsigned HALF_CLK_CYC       = (HALF_CLK_NS * CLK_KHZ + 999999) / 1000000;
   // Recovery time that the encoder needs after a word, in microseconds.
   localparam int unsigned RECOVERY_US        = 30;
   localparam int unsigned RECOVERY_CYC       = (RECOVERY_US * CLK_KHZ + 999) / 1000;
   // Seconds per minute, used when scaling speed to rpm.
   localparam int unsigned SEC_PER_MIN        = 60;
   // Degrees per revolution, used when scaling a count to an angle.
   localparam int unsigned DEG_PER_REV        = 360;
   // Quadrature counts per incremental signal period.
   localparam int unsigned QUAD_PER_PERIOD    = 4;

   // Link states.
   typedef enum logic [2:0] {
      SSIPR_IDLE,
      SSIPR_LOW,
      SSIPR_HIGH,
      SSIPR_RECOVER,
      SSIPR_DONE
   } ssipr_state_t;

endpackage : ssipr_pkg

// >>> hw/ssipr_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides and registered read data.
 * Assumes one clock and a synchronous active-high reset shared with its user.
 */
`timescale 1ns/1ps
module ssipr_fifo #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);

   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];        // Storage array.
   logic [AW-1:0]    wp_q;               // Write pointer.
   logic [AW-1:0]    rp_q;               // Read pointer.
   logic [AW:0]      cnt_q;              // Words held, including the output register.
   logic             push;               // A word enters this cycle.
   logic             pop;                // A word leaves this cycle.
   logic             load;               // The output register takes a new word.

   // The output register is refilled when it is empty or being drained.
   assign push     = in_valid && in_ready;
   assign pop      = out_valid && out_ready;
   assign in_ready = (cnt_q < (AW+1)'(DEPTH));
   assign load     = (cnt_q > (AW+1)'(out_valid)) && (!out_valid || out_ready);

   // Storage write; no reset is needed for the array.
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wp_q] <= in_data;
      end
   end

   // Pointers, fill count and the registered read side.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         wp_q      <= '0;
         rp_q      <= '0;
         cnt_q     <= '0;
         out_valid <= 1'b0;
         out_data  <= '0;
      end
      else
      begin
         if (push)
         begin
            wp_q <= wp_q + AW'(1);
         end
         if (load)
         begin
            out_data  <= mem[rp_q];
            rp_q      <= rp_q + AW'(1);
            out_valid <= 1'b1;
         end
         else if (pop)
         begin
            out_valid <= 1'b0;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule : ssipr_fifo

// >>> hw/ssipr_readout.sv
/*
 * Controller side of an absolute encoder readout over a synchronous serial link.
 * Generates the shift clock, collects the Gray-coded word, converts it, derives
 * speed once per sample period, and optionally follows incremental tracks.
 * Assumes enc_data, track_a and track_b arrive asynchronously from pins, and
 * that the consumer of the position stream drains it with ready/valid.
 */
// Behaviour
// - Word is 13 or 25 bits long.
// - Multi-turn: 13 position plus 12 turn bits.
// - Clock and data idle high.
// - Clock high past recovery gives fresh capture.
// - Sample each bit on the following rising edge; the code samples it at the end of the high phase it was presented in.
// - Read once per sample period, 125-250 us.
// - One count is 360 over two^single-turn bits.
// - Speed is delta over period, times 60.
// - Change below one count reports zero speed.
// - With tracks, read once then count only.
// - Asynchronous encoders use incremental tracks only.
// - No diagnostics or configuration over the link.
// - Count every track edge up/down, four per period.
`timescale 1ns/1ps
module ssipr_readout
   import ssipr_pkg::*;
#(
   parameter int unsigned SAMPLE_CYC = SAMPLE_MAX_CYC,
   parameter int unsigned FIFO_DEPTH = 32
) (
   input  wire logic                clk,
   input  wire logic                srst,
   input  wire logic                multi_turn,
   input  wire logic                use_tracks,
   input  wire logic                async_link,
   output logic                     enc_clk,
   input  wire logic                enc_data,
   input  wire logic                track_a,
   input  wire logic                track_b,
   output logic [WORD_MT-1:0]       pos_data,
   output logic                     pos_valid,
   input  wire logic                pos_ready,
   output logic [31:0]              speed_rpm,
   output logic                     speed_valid,
   output logic [31:0]              angle_mdeg,
   output logic                     overflow
);

   // Gray to binary conversion, used for the received word only.
   function automatic logic [WORD_MT-1:0] gray2bin(input logic [WORD_MT-1:0] g);
      logic [WORD_MT-1:0] b;
      b[WORD_MT-1] = g[WORD_MT-1];
      for (int i = WORD_MT - 2; i >= 0; i--)
      begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction : gray2bin

   // Rpm from a count change over one sample period.
   function automatic logic [31:0] to_rpm(input logic [ST_BITS-1:0] d);
      logic [63:0] p;
      p = 64'(d) * 64'(SEC_PER_MIN) * 64'(CLK_KHZ) * 64'd1000;
      return 32'(p / (64'(SAMPLE_CYC) << ST_BITS));
   endfunction : to_rpm

   ssipr_state_t          st_q;          // Link state.
   logic [1:0]            data_s_q;      // Data line synchroniser.
   logic [1:0]            a_s_q;         // Track A synchroniser.
   logic [1:0]            b_s_q;         // Track B synchroniser.
   logic                  a_q;           // Track A, previous synchronised value.
   logic                  b_q;           // Track B, previous synchronised value.
   logic [15:0]           tmr_q;         // Half period and recovery timer.
   logic [4:0]            bit_q;         // Clock pulses still to issue.
   logic [WORD_MT-1:0]    sh_q;          // Incoming shift register.
   logic [31:0]           per_q;         // Sample period timer.
   logic                  init_done_q;   // Startup read finished in track mode.
   logic [ST_BITS-1:0]    pos_q;         // Single-turn position, binary.
   logic [ST_BITS-1:0]    prev_q;        // Position at previous sample.
   logic [ST_BITS-1:0]    qpos_q;        // Quadrature up/down counter.
   logic [WORD_MT-1:0]    word_bin;      // Binary form of the received word.
   logic [4:0]            word_len;      // Pulses for the configured word.
   logic [ST_BITS-1:0]    cur_pos;       // Position used for speed.
   logic [ST_BITS-1:0]    diff;          // Signed-modulo change per period.
   logic [ST_BITS-1:0]    mag;           // Magnitude of the change.
   logic                  tick;          // Sample period boundary.
   logic                  want_read;     // A serial read should start.
   logic                  word_done;     // Word is complete in the shift register.
   logic                  a_edge;        // Any edge on track A.
   logic                  b_edge;        // Any edge on track B.
   logic                  up;            // Count direction.
   logic [WORD_MT-1:0]    fifo_in;       // Word aligned to the least bits.
   logic                  fifo_in_ready; // Space in the stream buffer.

   // Decoding of mode, conversions and quadrature direction.
   assign word_len  = multi_turn ? 5'(WORD_MT) : 5'(WORD_ST);
   assign fifo_in   = multi_turn ? sh_q : {{(WORD_MT-WORD_ST){1'b0}}, sh_q[WORD_ST-1:0]};
   assign word_bin  = gray2bin(fifo_in);
   assign tick      = (per_q == SAMPLE_CYC - 1);
   assign want_read = tick && !async_link && !(use_tracks && init_done_q);
   assign word_done = (st_q == SSIPR_RECOVER) && (tmr_q == 16'(RECOVERY_CYC));
   assign a_edge    = a_s_q[1] ^ a_q;
   assign b_edge    = b_s_q[1] ^ b_q;
   assign up        = a_s_q[1] ^ b_q;
   assign cur_pos   = (use_tracks || async_link) ? qpos_q : pos_q;
   assign diff      = cur_pos - prev_q;
   assign mag       = diff[ST_BITS-1] ? (~diff + ST_BITS'(1)) : diff;

   // Pin synchronisers; only the second stage is read.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         data_s_q <= 2'b11;
         a_s_q    <= 2'b00;
         b_s_q    <= 2'b00;
         a_q      <= 1'b0;
         b_q      <= 1'b0;
      end
      else
      begin
         data_s_q <= {data_s_q[0], enc_data};
         a_s_q    <= {a_s_q[0], track_a};
         b_s_q    <= {b_s_q[0], track_b};
         a_q      <= a_s_q[1];
         b_q      <= b_s_q[1];
      end
   end

   // Sample period timer.
   always_ff @(posedge clk)
   begin
      if (srst || tick)
      begin
         per_q <= '0;
      end
      else
      begin
         per_q <= per_q + 32'd1;
      end
   end

   // Link sequencer: idle high, word_len low/high pulses, then a high recovery.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         st_q    <= SSIPR_IDLE;
         enc_clk <= 1'b1;
         tmr_q   <= '0;
         bit_q   <= '0;
         sh_q    <= '0;
      end
      else
      begin
         case (st_q)
            SSIPR_IDLE:
            begin
               // The clock has rested high long enough, so the encoder captures anew.
               if (want_read)
               begin
                  st_q    <= SSIPR_LOW;
                  enc_clk <= 1'b0;
                  tmr_q   <= 16'(HALF_CLK_CYC - 1);
                  bit_q   <= word_len;
               end
            end
            SSIPR_LOW:
            begin
               // Rising edge: the encoder presents the next bit, which is taken at the end of this high phase.
               if (tmr_q == 16'd0)
               begin
                  st_q    <= SSIPR_HIGH;
                  enc_clk <= 1'b1;
                  tmr_q   <= 16'(HALF_CLK_CYC - 1);
                  bit_q   <= bit_q - 5'd1;
               end
               else
               begin
                  tmr_q <= tmr_q - 16'd1;
               end
            end
            SSIPR_HIGH:
            begin
               if (tmr_q != 16'd0)
               begin
                  tmr_q <= tmr_q - 16'd1;
               end
               else
               begin
                  // Shift at the end of the high phase, half a period after the rising edge that presented the bit.
                  sh_q <= {sh_q[WORD_MT-2:0], data_s_q[1]};
                  if (bit_q == 5'd0)
                  begin
                     st_q  <= SSIPR_RECOVER;
                     tmr_q <= 16'(RECOVERY_CYC);
                  end
                  else
                  begin
                     st_q    <= SSIPR_LOW;
                     enc_clk <= 1'b0;
                     tmr_q   <= 16'(HALF_CLK_CYC - 1);
                  end
               end
            end
            SSIPR_RECOVER:
            begin
               // Clock held high longer than the recovery time, so no repeated word.
               if (tmr_q == 16'd0)
               begin
                  st_q <= SSIPR_DONE;
               end
               else
               begin
                  tmr_q <= tmr_q - 16'd1;
               end
            end
            SSIPR_DONE:
            begin
               st_q <= SSIPR_IDLE;
            end
            default:
            begin
               st_q    <= SSIPR_IDLE;
               enc_clk <= 1'b1;
            end
         endcase
      end
   end

   // Position keeping: serial word loads, quadrature edges count.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pos_q       <= '0;
         qpos_q      <= '0;
         init_done_q <= 1'b0;
      end
      else
      begin
         if (word_done)
         begin
            pos_q <= word_bin[ST_BITS-1:0];
         end
         if (word_done && use_tracks)
         begin
            qpos_q      <= word_bin[ST_BITS-1:0];
            init_done_q <= 1'b1;
         end
         else if (a_edge || b_edge)
         begin
            qpos_q <= up ? qpos_q + ST_BITS'(1) : qpos_q - ST_BITS'(1);
         end
      end
   end

   // Speed and angle per sample period; the link only ever carries clock pulses.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         prev_q      <= '0;
         speed_rpm   <= '0;
         speed_valid <= 1'b0;
         angle_mdeg  <= '0;
         overflow    <= 1'b0;
      end
      else
      begin
         speed_valid <= tick;
         overflow    <= word_done && !fifo_in_ready;
         if (tick)
         begin
            prev_q     <= cur_pos;
            speed_rpm  <= (mag == '0) ? 32'd0 : to_rpm(mag);
            angle_mdeg <= 32'((64'(cur_pos) * 64'(DEG_PER_REV) * 64'd1000) >> ST_BITS);
         end
      end
   end

   // Stream buffer for received words in binary form.
   ssipr_fifo #(
      .WIDTH (WORD_MT),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .srst      (srst),
      .in_data   (word_bin),
      .in_valid  (word_done),
      .in_ready  (fifo_in_ready),
      .out_data  (pos_data),
      .out_valid (pos_valid),
      .out_ready (pos_ready)
   );

endmodule : ssipr_readout

// >>> test/ssipr_readout_checker.sv
/* Concurrent checks on the ports of the serial position readout.
   Assumes the bind below and the design parameters handed through it. */
`timescale 1ns/1ps
module ssipr_readout_checker
   import ssipr_pkg::*;
#(
   parameter int unsigned SAMPLE_CYC = SAMPLE_MAX_CYC,
   parameter int unsigned FIFO_DEPTH = 32
) (
   input wire logic               clk,
   input wire logic               srst,
   input wire logic               multi_turn,
   input wire logic               use_tracks,
   input wire logic               async_link,
   input wire logic               enc_clk,
   input wire logic               enc_data,
   input wire logic               track_a,
   input wire logic               track_b,
   input wire logic [WORD_MT-1:0] pos_data,
   input wire logic               pos_valid,
   input wire logic               pos_ready,
   input wire logic [31:0]        speed_rpm,
   input wire logic               speed_valid,
   input wire logic [31:0]        angle_mdeg,
   input wire logic               overflow
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   logic        last_q;  // Shift clock level one cycle ago.
   logic [31:0] run_q;   // Cycles spent at the present shift clock level.
   logic [5:0]  rise_q;  // Rising edges since the read began.
   logic [31:0] gap_q;   // Cycles since the last speed pulse.
   logic        seen_q;  // A speed pulse has been seen since reset.
   logic [7:0]  reads_q; // Reads started since reset.
   // A read begins when the clock falls after a long high spell.
   wire start_w = last_q && !enc_clk && (run_q > RECOVERY_CYC);
   // Measure shift clock phases and speed pulse spacing.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         last_q  <= 1'b1;
         run_q   <= '0;
         rise_q  <= '0;
         gap_q   <= '0;
         seen_q  <= 1'b0;
         reads_q <= '0;
      end
      else
      begin
         last_q  <= enc_clk;
         run_q   <= (enc_clk != last_q) ? 32'd1 : run_q + 32'd1;
         rise_q  <= start_w ? 6'd0 : rise_q + {5'd0, enc_clk && !last_q};
         gap_q   <= speed_valid ? 32'd1 : gap_q + 32'd1;
         seen_q  <= seen_q || speed_valid;
         reads_q <= reads_q + {7'd0, start_w};
      end
   end
   property p_low_half;
      $rose(enc_clk) |-> run_q == HALF_CLK_CYC;
   endproperty
   a_low_half : assert property (p_low_half)
      else $error("Shift clock low phase has the wrong length.");
   property p_high_gap;
      $fell(enc_clk) |-> run_q == HALF_CLK_CYC || run_q > RECOVERY_CYC;
   endproperty
   a_high_gap : assert property (p_high_gap)
      else $error("Shift clock high phase neither a half period nor a recovery.");
   property p_count;
      start_w |-> rise_q == 0 || rise_q == (multi_turn ? WORD_MT : WORD_ST);
   endproperty
   a_count : assert property (p_count)
      else $error("Pulse count of the previous read differs from the word length.");
   property p_period;
      speed_valid && seen_q |-> gap_q == SAMPLE_CYC;
   endproperty
   a_period : assert property (p_period)
      else $error("Speed pulses are not one sample period apart.");
   property p_async;
      async_link && enc_clk |=> enc_clk;
   endproperty
   a_async : assert property (p_async)
      else $error("Shift clock moved while the link is asynchronous.");
   property p_once;
      use_tracks && start_w |-> reads_q == 0;
   endproperty
   a_once : assert property (p_once)
      else $error("Second serial read while following the tracks.");
   property p_angle;
      !use_tracks && !async_link |-> angle_mdeg < 32'd360000;
   endproperty
   a_angle : assert property (p_angle)
      else $error("Angle beyond one revolution.");
   property p_hold;
      pos_valid && !pos_ready |=> pos_valid && $stable(pos_data);
   endproperty
   a_hold : assert property (p_hold)
      else $error("Offered word changed before it was taken.");
   c_read : cover property (start_w);
   c_overflow : cover property (overflow);
   c_speed : cover property (speed_valid && speed_rpm != 32'h0);
endmodule : ssipr_readout_checker
bind ssipr_readout ssipr_readout_checker #(.SAMPLE_CYC(SAMPLE_CYC), .FIFO_DEPTH(FIFO_DEPTH)) ssipr_readout_checker_inst (
   .clk(clk), .srst(srst), .multi_turn(multi_turn), .use_tracks(use_tracks), .async_link(async_link),
   .enc_clk(enc_clk), .enc_data(enc_data), .track_a(track_a), .track_b(track_b), .pos_data(pos_data),
   .pos_valid(pos_valid), .pos_ready(pos_ready), .speed_rpm(speed_rpm), .speed_valid(speed_valid),
   .angle_mdeg(angle_mdeg), .overflow(overflow));

// >>> test/ssipr_enc_model.sv
/* Behavioural absolute encoder answering on the synchronous serial link.
   Assumes the shift clock comes from the readout and idles high. */
`timescale 1ns/1ps
module ssipr_enc_model #(
   parameter real REC_NS = 30000.0
) (
   input  wire logic        enc_clk,
   input  wire logic        multi_turn,
   input  wire logic [24:0] position,
   output logic             enc_data
);
   logic [24:0] bin;    // Position cut to the word length.
   logic [24:0] word;   // Gray-coded word in the shift stage.
   realtime     t_rise; // Time of the last rising edge of a word.
   int          n;      // Word length in bits.
   assign bin = multi_turn ? position : {12'h000, position[12:0]};
   // One read per loop; the data line holds the last bit for 1500 ns, is low for the rest of the recovery, then rests high until the next word.
   initial
   begin
      enc_data = 1'b1;
      word = '0;
      t_rise = -1.0e9;
      forever
      begin
         @(negedge enc_clk);
         n = multi_turn ? 25 : 13;
         // Inside the recovery time the word already in the shift stage is sent again.
         if ($realtime - t_rise > REC_NS)
            word = bin ^ (bin >> 1);
         for (int i = n - 1; i >= 0; i--)
         begin
            @(posedge enc_clk);
            enc_data = word[i];
         end
         t_rise = $realtime;
         #1500 enc_data = 1'b0;
         #(REC_NS - 1500.0) enc_data = 1'b1;
      end
   end
endmodule : ssipr_enc_model

// >>> test/tb_ssipr_readout.sv
/* Self-checking bench for the serial position readout.
   Assumes the package, design, encoder model and checker are compiled first. */
`timescale 1ns/1ps
module tb_ssipr_readout;
   import ssipr_pkg::*;
   localparam int unsigned SAMPLE = 4100; // Shortened sample period in cycles.
   logic clk = 1'b0, srst = 1'b1, multi_turn = 1'b0, use_tracks = 1'b0, async_link = 1'b0;
   logic track_a = 1'b0, track_b = 1'b0, pos_ready = 1'b1, enc_clk, enc_data;
   logic pos_valid, speed_valid, overflow;
   logic [24:0] pos_data;
   logic [24:0] enc_pos = 25'h1fe1abc; // Upper bits must be ignored for 13-bit words.
   logic [31:0] speed_rpm, angle_mdeg;
   int err_count = 0, num_checks = 0;
   always #10 clk = ~clk;
   ssipr_readout #(.SAMPLE_CYC(SAMPLE), .FIFO_DEPTH(4)) ssipr_readout_inst (.clk(clk), .srst(srst),
      .multi_turn(multi_turn), .use_tracks(use_tracks), .async_link(async_link), .enc_clk(enc_clk),
      .enc_data(enc_data), .track_a(track_a), .track_b(track_b), .pos_data(pos_data), .pos_valid(pos_valid),
      .pos_ready(pos_ready), .speed_rpm(speed_rpm), .speed_valid(speed_valid), .angle_mdeg(angle_mdeg),
      .overflow(overflow));
   ssipr_enc_model ssipr_enc_model_inst (.enc_clk(enc_clk), .multi_turn(multi_turn), .position(enc_pos),
      .enc_data(enc_data));
   // Compare one value and count it.
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask : chk
   // Print the counts and the verdict, then stop.
   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   // Angle in millidegrees that a position count stands for.
   function automatic logic [31:0] mdeg(input longint p);
      return 32'((p * DEG_PER_REV * 1000) >> ST_BITS);
   endfunction : mdeg
   // Wait until the link rests, then reset into new modes.
   task automatic restart(input logic mt, input logic tr, input logic as);
      int n;
      n = 0;
      while (n < 1600)
      begin
         @(negedge clk);
         n = (enc_clk === 1'b1) ? n + 1 : 0;
      end
      @(posedge clk);
      srst <= 1'b1;
      multi_turn <= mt;
      use_tracks <= tr;
      async_link <= as;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
   endtask : restart
   // Wait for the next offered word; the consumer is always ready here.
   task automatic get_word(output logic [24:0] v);
      int n;
      n = 0;
      @(negedge clk);
      while (pos_valid !== 1'b1 && n < 2 * SAMPLE)
      begin
         @(negedge clk);
         n++;
      end
      v = pos_data;
      chk("pos_valid", 32'h1, {31'd0, pos_valid});
      @(posedge clk);
   endtask : get_word
   // Wait for the next speed pulse and return its value.
   task automatic get_speed(output logic [31:0] s);
      int n;
      n = 0;
      @(negedge clk);
      while (speed_valid !== 1'b1 && n < 2 * SAMPLE)
      begin
         @(negedge clk);
         n++;
      end
      s = speed_rpm;
      chk("speed_valid", 32'h1, {31'd0, speed_valid});
      @(posedge clk);
   endtask : get_speed
   // Single-turn word, still and moving speed, angle.
   task automatic t_single();
      logic [24:0] w;
      logic [31:0] s, top;
      get_word(w);
      chk("word13", 32'h00001abc, {7'd0, w});
      get_speed(s);
      get_speed(s);
      chk("speed_still", 32'h0, s);
      chk("angle", mdeg(64'h1abc), angle_mdeg);
      repeat (100) @(posedge clk);
      enc_pos <= 25'h1fe1ac1;
      top = 32'h0;
      repeat (3)
      begin
         get_speed(s);
         top = (s > top) ? s : top;
      end
      chk("speed", 32'((64'd5 * SEC_PER_MIN * CLK_KHZ * 1000) / (SAMPLE * (64'd1 << ST_BITS))), top);
   endtask : t_single
   // Multi-turn word of 25 bits.
   task automatic t_multi();
      logic [24:0] w;
      restart(1'b1, 1'b0, 1'b0);
      enc_pos <= 25'h1a3c5e7;
      get_word(w);
      chk("word25", 32'h01a3c5e7, {7'd0, w});
   endtask : t_multi
   // Fill the buffer until a word is dropped, then drain it.
   task automatic t_overflow();
      int n;
      pos_ready <= 1'b0;
      restart(1'b0, 1'b0, 1'b0);
      enc_pos <= 25'h0000ac1;
      n = 0;
      while (overflow !== 1'b1 && n < 6 * SAMPLE)
      begin
         @(negedge clk);
         n++;
      end
      chk("overflow", 32'h1, {31'd0, overflow});
      @(posedge clk);
      pos_ready <= 1'b1;
      n = 0;
      repeat (12)
      begin
         @(negedge clk);
         if (pos_valid === 1'b1)
            chk("drained", 32'h00000ac1, {7'd0, pos_data});
         n += (pos_valid === 1'b1) ? 1 : 0;
      end
      chk("drain_count", 32'd4, 32'(n));
      @(posedge clk);
   endtask : t_overflow
   // One serial read, then eight quadrature edges forward.
   task automatic t_tracks();
      logic [24:0] w;
      logic [31:0] s;
      restart(1'b0, 1'b1, 1'b0);
      enc_pos <= 25'd100;
      get_word(w);
      chk("init_word", 32'd100, {7'd0, w});
      for (int i = 0; i < 8; i++)
      begin
         repeat (20) @(posedge clk);
         if (i % 2 == 0)
            track_a <= ~track_a;
         else
            track_b <= ~track_b;
      end
      get_speed(s);
      get_speed(s);
      chk("track_angle", mdeg(108), angle_mdeg);
   endtask : t_tracks
   // Asynchronous link: shift clock rests high and no word comes.
   task automatic t_async();
      int n;
      restart(1'b0, 1'b0, 1'b1);
      n = 0;
      repeat (2 * SAMPLE)
      begin
         @(negedge clk);
         n += (pos_valid !== 1'b0 || enc_clk !== 1'b1) ? 1 : 0;
      end
      chk("async_quiet", 32'h0, 32'(n));
   endtask : t_async
   // Cut a hang short.
   initial
   begin
      #(100000 * 20);
      err_count++;
      print_verdict();
   end
   // Main sequence.
   initial
   begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      t_single();
      t_multi();
      t_overflow();
      t_tracks();
      t_async();
      print_verdict();
   end
endmodule : tb_ssipr_readout
